// ==== rtl/gpcd_top.sv ====
// Behaviour
// - Port C has eight pins, each with its own direction, attribute, data.
// - Direction bit cleared makes the pin input, set makes it output.
// - Reading a data register returns sampled pin levels.
// - Reading readback returns last written data; Port C readback read-only.
// - Data write sets output level, or pull choice for inputs.
// - Normal pin states decoded from attribute, direction, data bits.
// - Port D bit 5 uses its own decode, never driving high.
// - Port D bit 5 never drives a high level.
// - Port C pins may serve as segment outputs; GPIO after reset.
// - Segment-select bit set routes pin to segment output, except C7..C4 while converter enable is set.
// - Converter enable forces C7 input and C6..C4 outputs.
// - Converter port bits enable each converter output individually.
// - Port C strobe-enable bits enable each pin's strobe.
// - Port C wake-enable bits make pins key wake-up sources.
// - In sleep, a level change on an enabled pin wakes the system.
// - Port D has pins 7, 5, 3..0; bits 6 and 4 reserved.
// - Port D 1..0 share main crystal, 3..2 slow crystal; GPIO default.
// - Port D bit 7 defaults to infrared transmit output.
// - After reset every pin except D7 is a general input.
// - Port D strobe-enable bits enable each implemented pin's strobe.
// - Port D wake-enable bits make implemented pins wake sources.
// - Port D readback returns stored data, not pin levels.
`default_nettype none
module gpcd_top
	import gpcd_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Port C pads
	input wire logic [7:0] pc_in,
	output logic [7:0] pc_oe,
	output logic [7:0] pc_dout,
	output logic [7:0] pc_pu,
	output logic [7:0] pc_pd,
	// Port D pads
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_oe,
	output logic [7:0] pd_dout,
	output logic [7:0] pd_pu,
	output logic [7:0] pd_pd,
	// Alternate function sources, same clock
	input wire logic [7:0] seg_level,
	input wire logic [2:0] conv_level,
	input wire logic ir_tx_level,
	// Alternate function controls and returns
	output logic conv_in_level,
	output logic converter_enable,
	output logic [2:0] converter_port_enables,
	output logic main_crystal_en,
	output logic slow_crystal_en,
	// Strobe and wake-up
	output logic [7:0] port_c_strobe_bits,
	output logic [7:0] port_d_strobe_bits,
	input wire logic sleep,
	output logic wake_pulse
);
	// Configuration registers
	logic [7:0] c_dir_reg, d_dir_reg, c_att_reg, d_att_reg;
	logic [7:0] c_dat_reg, d_dat_reg, conv_reg, c_seg_reg;
	logic [7:0] c_stb_reg, d_stb_reg, c_wake_reg, d_wake_reg, d_alt_reg;
	// Pin synchronisers and filtered levels
	logic [7:0] c_s1_reg, c_s2_reg, c_s3_reg, c_pin_reg, c_pin_next;
	logic [7:0] d_s1_reg, d_s2_reg, d_s3_reg, d_pin_reg, d_pin_next;
	logic [7:0] rdata_next;
	gpcd_pin_t [7:0] c_ctl_next, d_ctl_next;
	logic wake_next;

	// Decode of attribute, direction, data into a pin state
	function automatic gpcd_pin_t pin_mode(input logic att, input logic dir,
		input logic dat, input logic nohigh);
		gpcd_pin_t p;
		p = PIN_FLOAT;
		case ({att, dir, dat})
			3'b001: p.pd = 1'b1;
			3'b101: p.pu = 1'b1;
			3'b010, 3'b111: p.oe = 1'b1;
			3'b011, 3'b110: begin
				// Reduced table floats here instead of driving high
				p.oe = !nohigh;
				p.dout = !nohigh;
			end
			default: p = PIN_FLOAT;
		endcase
		return p;
	endfunction

	// Port C direction, attribute and data writes
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			c_dir_reg <= RST_CFG;
			c_att_reg <= RST_CFG;
			c_dat_reg <= RST_CFG;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_C_DIR: c_dir_reg <= reg_wdata;
				OFS_ATT: c_att_reg <= reg_wdata;
				OFS_C_DAT: c_dat_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Port D direction, attribute and data writes, reserved bits dropped
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			d_dir_reg <= RST_CFG;
			d_att_reg <= RST_CFG;
			d_dat_reg <= RST_CFG;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_D_DIR: d_dir_reg <= reg_wdata & MASK_D;
				OFS_ATT: d_att_reg <= reg_wdata & MASK_D;
				OFS_D_DAT: d_dat_reg <= reg_wdata & MASK_D;
				default: ;
			endcase
		end
	end

	// Alternate function, strobe and wake-enable writes
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			conv_reg <= RST_CFG;
			c_seg_reg <= RST_CFG;
			c_stb_reg <= RST_CFG;
			d_stb_reg <= RST_CFG;
			c_wake_reg <= RST_CFG;
			d_wake_reg <= RST_CFG;
			d_alt_reg <= RST_CFG;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_CONV: conv_reg <= reg_wdata & MASK_CONV;
				OFS_C_SEG: c_seg_reg <= reg_wdata;
				OFS_C_STB: c_stb_reg <= reg_wdata;
				OFS_D_STB: d_stb_reg <= reg_wdata & MASK_D;
				OFS_C_WAKE: c_wake_reg <= reg_wdata;
				OFS_D_WAKE: d_wake_reg <= reg_wdata & MASK_D;
				OFS_D_ALT: d_alt_reg <= reg_wdata & MASK_D_ALT;
				default: ;
			endcase
		end
	end

	// Three-stage pad synchronisers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			c_s1_reg <= 8'h00;
			c_s2_reg <= 8'h00;
			c_s3_reg <= 8'h00;
			d_s1_reg <= 8'h00;
			d_s2_reg <= 8'h00;
			d_s3_reg <= 8'h00;
		end else begin
			c_s1_reg <= pc_in;
			c_s2_reg <= c_s1_reg;
			c_s3_reg <= c_s2_reg;
			d_s1_reg <= pd_in;
			d_s2_reg <= d_s1_reg;
			d_s3_reg <= d_s2_reg;
		end
	end

	// Level accepted only where stages two and three agree
	always_comb begin
		c_pin_next = (c_pin_reg & (c_s2_reg ^ c_s3_reg))
			| (c_s3_reg & ~(c_s2_reg ^ c_s3_reg));
		d_pin_next = ((d_pin_reg & (d_s2_reg ^ d_s3_reg))
			| (d_s3_reg & ~(d_s2_reg ^ d_s3_reg))) & MASK_D;
		wake_next = sleep && ((((c_pin_next ^ c_pin_reg) & c_wake_reg)
			| ((d_pin_next ^ d_pin_reg) & d_wake_reg)) != 8'h00);
	end

	// Filtered pin levels and wake pulse
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			c_pin_reg <= 8'h00;
			d_pin_reg <= 8'h00;
			wake_pulse <= 1'b0;
		end else begin
			c_pin_reg <= c_pin_next;
			d_pin_reg <= d_pin_next;
			wake_pulse <= wake_next;
		end
	end

	// Port C pin drive with alternate function override
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			c_ctl_next[i] = pin_mode(c_att_reg[i], c_dir_reg[i],
				c_dat_reg[i], 1'b0);
			if (conv_reg[CONV_EN_BIT] && i == CONV_PIN_IN) begin
				c_ctl_next[i] = PIN_FLOAT;
			end else if (conv_reg[CONV_EN_BIT] && i >= CONV_PIN_LO
				&& i < CONV_PIN_IN) begin
				c_ctl_next[i] = PIN_FLOAT;
				c_ctl_next[i].oe = 1'b1;
				c_ctl_next[i].dout = conv_reg[i - CONV_PIN_LO]
					& conv_level[i - CONV_PIN_LO];
			end else if (c_seg_reg[i]) begin
				c_ctl_next[i] = PIN_FLOAT;
				c_ctl_next[i].oe = 1'b1;
				c_ctl_next[i].dout = seg_level[i];
			end
		end
	end

	// Port D pin drive with crystal and infrared sharing
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			d_ctl_next[i] = pin_mode(d_att_reg[i], d_dir_reg[i],
				d_dat_reg[i], i == PD_NOHIGH_BIT);
			if (!MASK_D[i]) begin
				d_ctl_next[i] = PIN_FLOAT;
			end else if (i == PD_IR_BIT && !d_alt_reg[ALT_PD7_GPIO]) begin
				d_ctl_next[i] = PIN_FLOAT;
				d_ctl_next[i].oe = 1'b1;
				d_ctl_next[i].dout = ir_tx_level;
			end else if ((i < 2 && d_alt_reg[ALT_MAIN_XTAL])
				|| (i >= 2 && i < 4 && d_alt_reg[ALT_SLOW_XTAL])) begin
				d_ctl_next[i] = PIN_FLOAT;
			end
		end
	end

	// Registered pad outputs
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pc_oe <= 8'h00;
			pc_dout <= 8'h00;
			pc_pu <= 8'h00;
			pc_pd <= 8'h00;
			pd_oe <= 8'h00;
			pd_dout <= 8'h00;
			pd_pu <= 8'h00;
			pd_pd <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				pc_oe[i] <= c_ctl_next[i].oe;
				pc_dout[i] <= c_ctl_next[i].dout;
				pc_pu[i] <= c_ctl_next[i].pu;
				pc_pd[i] <= c_ctl_next[i].pd;
				pd_oe[i] <= d_ctl_next[i].oe;
				pd_dout[i] <= d_ctl_next[i].dout;
				pd_pu[i] <= d_ctl_next[i].pu;
				pd_pd[i] <= d_ctl_next[i].pd;
			end
		end
	end

	// Control outputs toward converter, crystals and strobe logic
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			conv_in_level <= 1'b0;
			converter_enable <= 1'b0;
			converter_port_enables <= 3'h0;
			main_crystal_en <= 1'b0;
			slow_crystal_en <= 1'b0;
			port_c_strobe_bits <= 8'h00;
			port_d_strobe_bits <= 8'h00;
		end else begin
			conv_in_level <= conv_reg[CONV_EN_BIT]
				& c_pin_reg[CONV_PIN_IN];
			converter_enable <= conv_reg[CONV_EN_BIT];
			converter_port_enables <= conv_reg[2:0];
			main_crystal_en <= d_alt_reg[ALT_MAIN_XTAL];
			slow_crystal_en <= d_alt_reg[ALT_SLOW_XTAL];
			port_c_strobe_bits <= c_stb_reg;
			port_d_strobe_bits <= d_stb_reg;
		end
	end

	// Read decode
	always_comb begin
		case (reg_addr)
			OFS_C_DIR: rdata_next = c_dir_reg;
			OFS_D_DIR: rdata_next = d_dir_reg;
			OFS_ATT: rdata_next = c_att_reg;
			OFS_C_DAT: rdata_next = c_pin_reg;
			OFS_D_DAT: rdata_next = d_pin_reg;
			OFS_C_RBK: rdata_next = c_dat_reg;
			OFS_D_RBK: rdata_next = d_dat_reg;
			OFS_CONV: rdata_next = conv_reg;
			OFS_C_STB: rdata_next = c_stb_reg;
			OFS_D_STB: rdata_next = d_stb_reg;
			OFS_C_WAKE: rdata_next = c_wake_reg;
			OFS_D_WAKE: rdata_next = d_wake_reg;
			OFS_C_SEG: rdata_next = c_seg_reg;
			OFS_D_ALT: rdata_next = d_alt_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : 8'h00;
		end
	end

	// Bus sequences
	sequence s_rd_c_rbk;
		reg_rd && reg_addr == OFS_C_RBK;
	endsequence
	sequence s_rd_c_pin;
		reg_rd && reg_addr == OFS_C_DAT;
	endsequence
	sequence s_wr_c_dat;
		reg_wr && reg_addr == OFS_C_DAT;
	endsequence

	property p_readback;
		@(posedge mclk) disable iff (!nrst)
		s_wr_c_dat ##1 s_rd_c_rbk |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback)
		else $error("Port C readback differs from written data");

	property p_pin_read;
		@(posedge mclk) disable iff (!nrst)
		s_rd_c_pin |=> reg_rdata == $past(c_pin_reg);
	endproperty
	a_pin_read: assert property (p_pin_read)
		else $error("Port C data read is not the pin level");

	property p_pd5_no_high;
		@(posedge mclk) disable iff (!nrst)
		pd_oe[PD_NOHIGH_BIT] |-> !pd_dout[PD_NOHIGH_BIT];
	endproperty
	a_pd5_no_high: assert property (p_pd5_no_high)
		else $error("Port D bit 5 drives high");

	property p_conv_force;
		@(posedge mclk) disable iff (!nrst)
		conv_reg[CONV_EN_BIT] |=> !pc_oe[7] && pc_oe[6:4] == 3'b111;
	endproperty
	a_conv_force: assert property (p_conv_force)
		else $error("Converter pin directions not forced");

	property p_seg_route;
		@(posedge mclk) disable iff (!nrst)
		c_seg_reg[0] |=> pc_oe[0] && pc_dout[0] == $past(seg_level[0]);
	endproperty
	a_seg_route: assert property (p_seg_route)
		else $error("Segment select does not own pin C0");

	property p_reserved_zero;
		@(posedge mclk) disable iff (!nrst)
		reg_rd ##1 1'b1 |-> (pd_oe[6] | pd_oe[4] | pd_pu[6] | pd_pd[4]) == 1'b0
			&& ($past(reg_addr) != OFS_D_RBK || reg_rdata[6] == 1'b0
			&& reg_rdata[4] == 1'b0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("Port D reserved bit active");

	property p_wake;
		@(posedge mclk) disable iff (!nrst)
		sleep && ((c_pin_next ^ c_pin_reg) & c_wake_reg) != 8'h00
			|=> wake_pulse;
	endproperty
	a_wake: assert property (p_wake)
		else $error("Enabled pin change in sleep gave no wake");

	property p_input_dir;
		@(posedge mclk) disable iff (!nrst)
		!c_dir_reg[0] && !c_seg_reg[0] |=> !pc_oe[0];
	endproperty
	a_input_dir: assert property (p_input_dir)
		else $error("Input pin C0 is driven");

	property p_drive_high;
		@(posedge mclk) disable iff (!nrst)
		{c_att_reg[1], c_dir_reg[1], c_dat_reg[1]} == 3'b011
			&& !c_seg_reg[1] |=> pc_oe[1] && pc_dout[1];
	endproperty
	a_drive_high: assert property (p_drive_high)
		else $error("Mode 011 on C1 does not drive high");

	property p_ir_default;
		@(posedge mclk) disable iff (!nrst)
		!d_alt_reg[ALT_PD7_GPIO] |=> pd_oe[7]
			&& pd_dout[7] == $past(ir_tx_level);
	endproperty
	a_ir_default: assert property (p_ir_default)
		else $error("Port D bit 7 not carrying infrared output");
endmodule // gpcd_top
`default_nettype wire

// ==== rtl/gpcd_pkg.sv ====
`default_nettype none
// Register map, field layout and pin encodings of ports C and D
package gpcd_pkg;
	// Register offsets
	localparam logic [7:0] OFS_C_DIR = 8'h01;
	localparam logic [7:0] OFS_D_DIR = 8'h02;
	localparam logic [7:0] OFS_ATT = 8'h05; // Shared by C and D attribute
	localparam logic [7:0] OFS_C_DAT = 8'h09;
	localparam logic [7:0] OFS_D_DAT = 8'h0a;
	localparam logic [7:0] OFS_C_RBK = 8'h0e;
	localparam logic [7:0] OFS_D_RBK = 8'h0f;
	localparam logic [7:0] OFS_CONV = 8'h1e;
	localparam logic [7:0] OFS_C_STB = 8'h2e;
	localparam logic [7:0] OFS_D_STB = 8'h2f;
	localparam logic [7:0] OFS_C_WAKE = 8'h38;
	localparam logic [7:0] OFS_D_WAKE = 8'h39;
	localparam logic [7:0] OFS_C_SEG = 8'h4c;
	localparam logic [7:0] OFS_D_ALT = 8'h50;
	// Implemented-bit masks
	localparam logic [7:0] MASK_D = 8'haf;
	localparam logic [7:0] MASK_CONV = 8'h0f;
	localparam logic [7:0] MASK_D_ALT = 8'h07;
	// Field positions
	localparam int CONV_EN_BIT = 3;
	localparam int CONV_PIN_IN = 7;
	localparam int CONV_PIN_LO = 4;
	localparam int PD_NOHIGH_BIT = 5;
	localparam int PD_IR_BIT = 7;
	localparam int ALT_MAIN_XTAL = 0;
	localparam int ALT_SLOW_XTAL = 1;
	localparam int ALT_PD7_GPIO = 2;
	// Reset value of every configuration register
	localparam logic [7:0] RST_CFG = 8'h00;
	// Per-pin drive decision
	typedef struct packed {
		logic oe;
		logic dout;
		logic pu;
		logic pd;
	} gpcd_pin_t;
	localparam gpcd_pin_t PIN_FLOAT = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage
`default_nettype wire

// ==== verification/gpcd_pads.sv ====
`default_nettype none
// Outside world seen by the pads of one port
module gpcd_pads (
	// Pad controls from the block
	input wire logic [7:0] oe,
	input wire logic [7:0] dout,
	input wire logic [7:0] pu,
	input wire logic [7:0] pd,
	// Level forced by the board on undriven, unpulled pins
	input wire logic [7:0] ext,
	// Resolved level fed back to the block
	output logic [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Block driver wins, then the pull resistors, then the board
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (oe[i])
				pin[i] = dout[i];
			else if (pu[i])
				pin[i] = 1'b1;
			else if (pd[i])
				pin[i] = 1'b0;
			else
				pin[i] = ext[i];
		end
	end
endmodule // gpcd_pads
`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import gpcd_pkg::*;
	logic mclk, nrst, reg_wr, reg_rd, sleep, ir_tx_level, wake_pulse;
	logic conv_in_level, converter_enable, main_crystal_en, slow_crystal_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, seg_level, rv, v, ext_c, ext_d;
	logic [7:0] pc_in, pc_oe, pc_dout, pc_pu, pc_pd;
	logic [7:0] pd_in, pd_oe, pd_dout, pd_pu, pd_pd;
	logic [7:0] port_c_strobe_bits, port_d_strobe_bits;
	logic [2:0] conv_level, converter_port_enables;
	logic [31:0] seed;
	int errors, n_compared, nw, b;
	logic [7:0] wv [10];
	logic [7:0] ra [10] = '{OFS_C_DIR, OFS_D_DIR, OFS_ATT, OFS_C_STB,
		OFS_D_STB, OFS_C_WAKE, OFS_D_WAKE, OFS_C_SEG, OFS_CONV, OFS_D_ALT};
	logic [7:0] rm [10] = '{8'hff, MASK_D, 8'hff, 8'hff, MASK_D, 8'hff,
		MASK_D, 8'hff, MASK_CONV, MASK_D_ALT};

	// Block under test and both pad models
	gpcd_top i_gpcd_top (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .pc_in, .pc_oe, .pc_dout, .pc_pu, .pc_pd,
		.pd_in, .pd_oe, .pd_dout, .pd_pu, .pd_pd, .seg_level, .conv_level,
		.ir_tx_level, .conv_in_level, .converter_enable,
		.converter_port_enables, .main_crystal_en, .slow_crystal_en,
		.port_c_strobe_bits, .port_d_strobe_bits, .sleep, .wake_pulse);
	gpcd_pads i_pads_c (.oe(pc_oe), .dout(pc_dout), .pu(pc_pu), .pd(pc_pd),
		.ext(ext_c), .pin(pc_in));
	gpcd_pads i_pads_d (.oe(pd_oe), .dout(pd_dout), .pu(pd_pu), .pd(pd_pd),
		.ext(ext_d), .pin(pd_in));

	// Xorshift source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected {drive, high, pull-up, pull-down} from att, dir, data
	function automatic logic [3:0] pin_exp(input int k,
		input int nohigh);
		case (k[2:0])
			3'b001: return 4'b0001;
			3'b010, 3'b111: return 4'b1000;
			3'b011, 3'b110: return nohigh ? 4'b0000 : 4'b1100;
			3'b101: return 4'b0010;
			default: return 4'b0000;
		endcase
	endfunction

	// Observed state of one pad
	function automatic logic [3:0] pinv(input logic [7:0] oe,
		input logic [7:0] dout, input logic [7:0] pu, input logic [7:0] pd,
		input int i);
		return {oe[i], oe[i] & dout[i], pu[i], pd[i]};
	endfunction

	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		`CHK(rv, e)
	endtask

	// Port C data write followed with no gap by a readback read
	task automatic wrchk(input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= OFS_C_DAT;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= OFS_C_RBK;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		`CHK(rv, d)
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Toggle one board level and count wake pulses
	task automatic wake(input logic d, input int bit_n, output int n);
		n = 0;
		@(posedge mclk);
		if (d)
			ext_d[bit_n] <= ~ext_d[bit_n];
		else
			ext_c[bit_n] <= ~ext_c[bit_n];
		repeat (10) begin
			@(posedge mclk);
			#1 if (wake_pulse === 1'b1) n++;
		end
	endtask

	task automatic results;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		results();
	end

	// Main sequence
	initial begin
		{nrst, reg_wr, reg_rd, sleep} = 4'h0;
		{reg_addr, reg_wdata, seg_level, ext_c, ext_d} = '0;
		conv_level = 3'h0;
		ir_tx_level = 1'b1;
		seed = 32'd95;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		settle(3);
		`CHK({pc_oe, pc_pu, pc_pd}, 24'h0)
		`CHK({pd_oe, pd_dout}, 16'h8080)
		for (int i = 0; i < 10; i++) chkrd(ra[i], 8'h00);
		chkrd(OFS_C_RBK, 8'h00);
		chkrd(8'h77, 8'h00);
		// Random write and readback with reserved bits dropped
		repeat (3) begin
			for (int i = 0; i < 10; i++) begin
				v = 8'(xs());
				wv[i] = v & rm[i];
				wr(ra[i], v);
				chkrd(ra[i], wv[i]);
			end
			settle(2);
			`CHK(port_c_strobe_bits, wv[3])
			`CHK(converter_enable, wv[8][CONV_EN_BIT])
			`CHK(converter_port_enables, wv[8][2:0])
			`CHK(main_crystal_en, wv[9][ALT_MAIN_XTAL])
			`CHK(slow_crystal_en, wv[9][ALT_SLOW_XTAL])
		end
		for (int i = 0; i < 10; i++) wr(ra[i], 8'h00);
		v = 8'(xs());
		wr(OFS_C_STB, v);
		wr(OFS_D_STB, v);
		settle(2);
		`CHK(port_c_strobe_bits, v)
		`CHK(port_d_strobe_bits, v & MASK_D)
		// Every attribute, direction, data combination
		for (int k = 0; k < 8; k++) begin
			wr(OFS_ATT, {8{k[2]}});
			wr(OFS_C_DIR, {8{k[1]}});
			wr(OFS_D_DIR, {8{k[1]}});
			wr(OFS_C_DAT, {8{k[0]}});
			wr(OFS_D_DAT, {8{k[0]}});
			settle(2);
			b = int'(xs() % 8);
			`CHK(pinv(pc_oe, pc_dout, pc_pu, pc_pd, b), pin_exp(k, 0))
			`CHK(pinv(pd_oe, pd_dout, pd_pu, pd_pd, 0), pin_exp(k, 0))
			`CHK(pinv(pd_oe, pd_dout, pd_pu, pd_pd, 5), pin_exp(k, 1))
		end
		chkrd(OFS_D_RBK, MASK_D);
		settle(6);
		chkrd(OFS_D_DAT, 8'h80);
		// Pin levels against stored data on Port C
		wr(OFS_ATT, 8'h00);
		wr(OFS_C_DIR, 8'h00);
		wr(OFS_C_DAT, 8'h00);
		ext_c <= 8'(xs());
		settle(8);
		chkrd(OFS_C_DAT, ext_c);
		chkrd(OFS_C_RBK, 8'h00);
		wr(OFS_ATT, 8'hff);
		wrchk(8'hff);
		wr(OFS_C_RBK, 8'h00);
		settle(8);
		chkrd(OFS_C_DAT, 8'hff);
		chkrd(OFS_C_RBK, 8'hff);
		// Segment and converter take over the pads
		seg_level <= 8'(xs());
		wr(OFS_C_SEG, 8'hff);
		settle(2);
		`CHK({pc_oe, pc_dout, pc_pu}, {8'hff, seg_level, 8'h00})
		conv_level <= 3'b111;
		wr(OFS_CONV, 8'h0a);
		settle(2);
		`CHK({pc_oe[7:4], pc_dout[6:4]}, 7'b0111010)
		conv_level <= 3'b101;
		wr(OFS_CONV, 8'h0f);
		settle(8);
		`CHK({converter_enable, pc_dout[6:4]}, 4'hd)
		`CHK(converter_port_enables, 3'b111)
		`CHK(conv_in_level, ext_c[7])
		wr(OFS_CONV, 8'h00);
		wr(OFS_C_SEG, 8'h00);
		// Crystal sharing and infrared pin release
		wr(OFS_D_ALT, 8'h03);
		settle(2);
		`CHK({main_crystal_en, slow_crystal_en}, 2'b11)
		`CHK(pd_oe[3:0] | pd_pu[3:0] | pd_pd[3:0], 4'h0)
		wr(OFS_D_ALT, 8'h04);
		settle(2);
		`CHK({pd_oe[7], pd_dout[7]}, 2'b10)
		wr(OFS_D_ALT, 8'h00);
		settle(2);
		`CHK({pd_oe[7], pd_dout[7]}, 2'b11)
		ir_tx_level <= 1'b0;
		settle(2);
		`CHK({pd_oe[7], pd_dout[7]}, 2'b10)
		// Key wake-up
		wr(OFS_ATT, 8'h00);
		wr(OFS_C_DAT, 8'h00);
		wr(OFS_D_DIR, 8'h00);
		wr(OFS_D_DAT, 8'h00);
		wr(OFS_C_WAKE, 8'h01);
		wr(OFS_D_WAKE, 8'h01);
		settle(8);
		sleep <= 1'b1;
		wake(1'b0, 0, nw);
		`CHK(nw, 1)
		wake(1'b0, 1, nw);
		`CHK(nw, 0)
		wake(1'b1, 0, nw);
		`CHK(nw, 1)
		wake(1'b1, 2, nw);
		`CHK(nw, 0)
		v = 8'(xs());
		wr(OFS_C_WAKE, v);
		b = int'(xs() % 8);
		wake(1'b0, b, nw);
		`CHK(nw, int'(v[b]))
		sleep <= 1'b0;
		wake(1'b0, b, nw);
		`CHK(nw, 0)
		results();
	end
endmodule // tb
`default_nettype wire
